//--- common/cps_pkg.sv
// Constants, types and register map of the compressor protection supervisor
package cps_pkg;

   // Time base
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned STEP_S = 90;
   localparam int unsigned OFF_DELAY_MIN = 3;
   localparam int unsigned SAG_RESTART_MIN = 30;
   localparam logic [15:0] STEP_TICKS = 16'(STEP_S * 1000 / TICK_MS);
   localparam logic [15:0] OFF_TICKS = 16'(OFF_DELAY_MIN * 60000 / TICK_MS);
   localparam logic [15:0] SAG_TICKS = 16'(SAG_RESTART_MIN * 60000 / TICK_MS);
   localparam logic [7:0] HYST_TENTHS_F = 8'h24; // 3.6 F rise above 32 F base = 35.6 F

   // Ladder constants
   localparam logic [7:0] STEP_NORMAL_HZ = 8'h08;
   localparam logic [7:0] STEP_HIGH_HZ = 8'h1e;
   localparam logic [2:0] TRIP_LIMIT = 3'h6;
   localparam int unsigned NPROT = 4;

   // APB map (byte addresses)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_IRQ_STAT = 8'h08;
   localparam logic [7:0] A_IRQ_EN = 8'h0c;
   localparam logic [7:0] A_IRQ_CLR = 8'h10;
   localparam logic [7:0] A_FREQ = 8'h14;
   localparam logic [7:0] A_TH_BASE = 8'h20; // 4 protections x 4 words
   localparam logic [7:0] A_CLR_BASE = 8'h60; // Clearing time per protection, ticks
   localparam logic [7:0] A_SAG = 8'h70;

   // Reset values
   localparam logic [7:0] FREQ_MIN_RST = 8'h14;
   localparam logic [7:0] FREQ_MAX_RST = 8'h5a;
   localparam logic [15:0] CLR_TIME_RST = 16'h4650;

   // Protection indices
   localparam int unsigned P_COOL = 0;
   localparam int unsigned P_HEAT = 1;
   localparam int unsigned P_DISC = 2;
   localparam int unsigned P_CUR = 3;

   typedef enum logic [1:0] {M_OFF = 2'h0, M_FAN = 2'h1, M_COOL = 2'h3, M_HEAT = 2'h2} mode_e;
   // Supervisor states, Gray along run -> stopped -> locked
   typedef enum logic [1:0] {S_RUN = 2'h0, S_STOP = 2'h1, S_LOCK = 2'h3, S_SAG = 2'h2} sup_e;

   // Four ascending thresholds of one ladder
   typedef struct packed {
      logic [15:0] lim;
      logic [15:0] norm;
      logic [15:0] high;
      logic [15:0] stop;
   } ladder_s;

   typedef struct packed {
      logic [15:0] coil_out;
      logic [15:0] coil_in;
      logic [15:0] disc;
      logic [15:0] cur;
   } sense_s;

endpackage

//--- verilog/comp_protect.sv
// Compressor protection supervisor with APB register access
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module comp_protect
   import cps_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYC,
   parameter logic [15:0] STEP_T = STEP_TICKS,
   parameter logic [15:0] OFF_T = OFF_TICKS,
   parameter logic [15:0] SAG_T = SAG_TICKS
) (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [15:0] COIL_OUT_TEMP,
   input wire logic [15:0] COIL_IN_TEMP,
   input wire logic [15:0] DISCHARGE_TEMP,
   input wire logic [15:0] AC_INPUT_CURRENT,
   input wire logic [15:0] DC_LINK_VOLTAGE,
   input wire logic KEY_ONOFF,
   output logic [7:0] FREQ_LIMIT,
   output logic RAISE_BLOCK,
   output logic STOP_REQ,
   output logic IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Sensor inputs cross in from the sensing front end: two flops each
   sense_s s1_q, s2_q;
   logic [15:0] v1_q, v2_q;
   logic k1_q, k2_q, k3_q;
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s1_q <= '0;
         s2_q <= '0;
         v1_q <= 16'h0000;
         v2_q <= 16'h0000;
         k1_q <= 1'b0;
         k2_q <= 1'b0;
         k3_q <= 1'b0;
      end else begin
         s1_q <= '{COIL_OUT_TEMP, COIL_IN_TEMP, DISCHARGE_TEMP, AC_INPUT_CURRENT};
         s2_q <= s1_q;
         v1_q <= DC_LINK_VOLTAGE;
         v2_q <= v1_q;
         k1_q <= KEY_ONOFF;
         k2_q <= k1_q;
         k3_q <= k2_q;
      end
   end
   logic key_press;
   assign key_press = k2_q & ~k3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Shared time base: one prescaler, every timer counts its ticks
   logic [31:0] pre_q;
   logic tick;
   assign tick = (pre_q == TICK_DIV - 1);
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) pre_q <= 32'h00000000;
      else if (tick) pre_q <= 32'h00000000;
      else pre_q <= pre_q + 32'h00000001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   mode_e mode_q;
   logic [7:0] fmin_q, fmax_q, fcur_q;
   ladder_s th_q [NPROT];
   logic [15:0] clr_t_q [NPROT];
   logic [15:0] sag_th_q, sag_det_q;
   logic [7:0] irq_en_q, irq_st_q;
   logic wr, rd;
   assign wr = PSEL & PENABLE & PWRITE;
   assign rd = PSEL & ~PENABLE & ~PWRITE;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_q <= M_OFF;
         fmin_q <= FREQ_MIN_RST;
         fmax_q <= FREQ_MAX_RST;
         for (int i = 0; i < NPROT; i++) begin
            th_q[i] <= '1;
            clr_t_q[i] <= CLR_TIME_RST;
         end
         sag_th_q <= 16'h0000;
         sag_det_q <= 16'h000a;
         irq_en_q <= 8'h00;
      end else if (wr) begin
         case (PADDR)
            A_CTRL: mode_q <= mode_e'(PWDATA[1:0]);
            A_FREQ: begin
               fmin_q <= PWDATA[7:0];
               fmax_q <= PWDATA[15:8];
            end
            A_IRQ_EN: irq_en_q <= PWDATA[7:0];
            A_SAG: begin
               sag_th_q <= PWDATA[15:0];
               sag_det_q <= PWDATA[31:16];
            end
            default: begin
               if (PADDR >= A_TH_BASE && PADDR < A_CLR_BASE) begin
                  case (PADDR[3:2])
                     2'h0: th_q[PADDR[5:4] - 2'h2].lim <= PWDATA[15:0];
                     2'h1: th_q[PADDR[5:4] - 2'h2].norm <= PWDATA[15:0];
                     2'h2: th_q[PADDR[5:4] - 2'h2].high <= PWDATA[15:0];
                     default: th_q[PADDR[5:4] - 2'h2].stop <= PWDATA[15:0];
                  endcase
               end else if (PADDR >= A_CLR_BASE && PADDR < A_SAG) begin
                  clr_t_q[PADDR[3:2]] <= PWDATA[15:0];
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-protection ladder: band, trip and counter
   logic [15:0] val [NPROT];
   assign val[P_COOL] = s2_q.coil_out;
   assign val[P_HEAT] = s2_q.coil_in;
   assign val[P_DISC] = s2_q.disc;
   assign val[P_CUR] = s2_q.cur;

   logic [NPROT-1:0] act, in_lim, in_norm, in_high, at_stop, start_ok;
   logic [2:0] trips_q [NPROT];
   logic [NPROT-1:0] lock;
   sup_e st_q;
   logic [15:0] off_q, step_q, run_q [NPROT], sag_cnt_q, sag_rs_q;
   logic at_min_q, comp_on;
   assign comp_on = (st_q == S_RUN) && (mode_q == M_COOL || mode_q == M_HEAT);
   logic dwell_done;
   assign dwell_done = at_min_q && (step_q >= STEP_T);

   genvar g;
   generate
      for (g = 0; g < NPROT; g++) begin : g_prot
         if (g == P_COOL) assign act[g] = (mode_q == M_COOL);
         else if (g == P_HEAT) assign act[g] = (mode_q == M_HEAT);
         else assign act[g] = 1'b1;
         assign in_lim[g] = act[g] && val[g] >= th_q[g].lim && val[g] < th_q[g].norm;
         assign in_norm[g] = act[g] && val[g] >= th_q[g].norm && val[g] < th_q[g].high;
         assign in_high[g] = act[g] && val[g] >= th_q[g].high && val[g] < th_q[g].stop;
         assign at_stop[g] = act[g] && val[g] >= th_q[g].stop;
         // Limit minus hysteresis for start check; threshold holds the release point
         assign start_ok[g] = !act[g] || val[g] < th_q[g].lim;
         assign lock[g] = (trips_q[g] >= TRIP_LIMIT);

         // Run time since start; counter clears past the clearing time
         always_ff @(posedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) run_q[g] <= 16'h0000;
            else if (!comp_on) run_q[g] <= 16'h0000;
            else if (tick && run_q[g] != 16'hffff) run_q[g] <= run_q[g] + 16'h0001;
         end

         // Consecutive stop counter
         always_ff @(posedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) trips_q[g] <= 3'h0;
            else if (comp_on && (at_stop[g] || (dwell_done && (in_norm[g] || in_high[g]))))
               trips_q[g] <= lock[g] ? trips_q[g] : trips_q[g] + 3'h1;
            else if (lock[g] && key_press) trips_q[g] <= 3'h0;
            // Off or fan mode drops pending troubles, but never a latched fault
            else if (!lock[g] && (mode_q == M_OFF || mode_q == M_FAN)) trips_q[g] <= 3'h0;
            else if (comp_on && run_q[g] > clr_t_q[g]) trips_q[g] <= 3'h0;
         end
      end
   endgenerate

   logic any_red, any_norm, any_high, any_trip, all_ok;
   assign any_norm = |in_norm;
   assign any_high = |in_high;
   assign any_red = any_norm | any_high;
   assign any_trip = |at_stop | (dwell_done & any_red);
   assign all_ok = &start_ok;

   ////////////////////////////////////////////////////////////////////////////
   // DC link sag detection while running
   logic sag_trip;
   assign sag_trip = comp_on && (v2_q < sag_th_q) && (sag_cnt_q >= sag_det_q);
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) sag_cnt_q <= 16'h0000;
      else if (!comp_on || v2_q >= sag_th_q) sag_cnt_q <= 16'h0000;
      else if (tick && sag_cnt_q != 16'hffff) sag_cnt_q <= sag_cnt_q + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supervisor state
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) st_q <= S_STOP;
      else begin
         case (st_q)
            S_RUN: begin
               if (sag_trip) st_q <= S_SAG;
               else if (|lock) st_q <= S_LOCK;
               else if (any_trip || mode_q == M_OFF || mode_q == M_FAN) st_q <= S_STOP;
            end
            S_STOP: begin
               if (|lock) st_q <= S_LOCK;
               // Failed start check stays stopped, counts no trip
               else if (off_q >= OFF_T && all_ok) st_q <= S_RUN;
            end
            S_LOCK: if (!(|lock)) st_q <= S_STOP;
            S_SAG: if (off_q >= SAG_T) st_q <= S_STOP;
            default: st_q <= S_STOP;
         endcase
      end
   end

   // Off time since stop, shared tick
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) off_q <= 16'h0000;
      else if (st_q == S_RUN) off_q <= 16'h0000;
      else if (tick && off_q != 16'hffff) off_q <= off_q + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frequency limit stepping every 90 s in reduction bands
   logic [7:0] step_amt;
   assign step_amt = any_high ? STEP_HIGH_HZ : STEP_NORMAL_HZ;
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         fcur_q <= FREQ_MAX_RST;
         step_q <= 16'h0000;
         at_min_q <= 1'b0;
      end else if (!comp_on || !any_red) begin
         fcur_q <= (|in_lim && comp_on) ? fcur_q : fmax_q;
         step_q <= 16'h0000;
         at_min_q <= 1'b0;
      end else if (tick) begin
         if (step_q >= STEP_T) begin
            step_q <= 16'h0000;
            if (fcur_q <= fmin_q + step_amt) begin
               fcur_q <= fmin_q;
               at_min_q <= 1'b1;
            end else fcur_q <= fcur_q - step_amt;
         end else step_q <= step_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and interrupt status
   logic [7:0] ev;
   assign ev = {4'h0, st_q == S_RUN && sag_trip, |lock, st_q == S_RUN && any_trip, any_red};
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         FREQ_LIMIT <= 8'h00;
         RAISE_BLOCK <= 1'b0;
         STOP_REQ <= 1'b1;
         IRQ <= 1'b0;
         irq_st_q <= 8'h00;
      end else begin
         FREQ_LIMIT <= comp_on ? fcur_q : 8'h00;
         RAISE_BLOCK <= |in_lim | any_red;
         STOP_REQ <= !comp_on;
         // Set wins over clear
         irq_st_q <= (irq_st_q & ~((wr && PADDR == A_IRQ_CLR) ? PWDATA[7:0] : 8'h00)) | ev;
         IRQ <= |(irq_st_q & irq_en_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read path: data registered in setup, ready in access
   logic [31:0] rdat;
   always_comb begin
      rdat = 32'h00000000;
      case (PADDR)
         A_CTRL: rdat = {30'h0, mode_q};
         A_STATUS: rdat = {17'h0, trips_q[P_CUR], trips_q[P_DISC], lock, st_q, 2'h0};
         A_IRQ_STAT: rdat = {24'h0, irq_st_q};
         A_IRQ_EN: rdat = {24'h0, irq_en_q};
         A_FREQ: rdat = {8'h0, fcur_q, fmax_q, fmin_q};
         A_SAG: rdat = {sag_det_q, sag_th_q};
         default: begin
            if (PADDR >= A_TH_BASE && PADDR < A_CLR_BASE) begin
               case (PADDR[3:2])
                  2'h0: rdat = {16'h0, th_q[PADDR[5:4] - 2'h2].lim};
                  2'h1: rdat = {16'h0, th_q[PADDR[5:4] - 2'h2].norm};
                  2'h2: rdat = {16'h0, th_q[PADDR[5:4] - 2'h2].high};
                  default: rdat = {16'h0, th_q[PADDR[5:4] - 2'h2].stop};
               endcase
            end else if (PADDR >= A_CLR_BASE && PADDR < A_SAG) begin
               rdat = {16'h0, clr_t_q[PADDR[3:2]]};
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         if (rd) PRDATA <= rdat;
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & (PADDR[1:0] != 2'h0 || PADDR > A_SAG);
      end
   end

endmodule // comp_protect

//--- tb/comp_protect_sva.sv
// Port checks for the protection supervisor
`timescale 1ns/1ps
module comp_protect_sva
   import cps_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [7:0] FREQ_LIMIT,
   input wire logic RAISE_BLOCK,
   input wire logic STOP_REQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////////////////////////
   // Steps: a bus setup cycle, and a stop held for eight cycles
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_held;
      STOP_REQ [*8];
   endsequence
   a_ready_after_setup: assert property (s_setup |=> PREADY)
      else $error("no ready after setup");
   a_ready_one: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access phase");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("refused read not zero");
   a_boot_delay: assert property ($rose(RST_B) |-> s_held)
      else $error("run too soon after reset");
   a_restart_delay: assert property ($rose(STOP_REQ) |-> s_held)
      else $error("restart too soon");
   a_stop_freq: assert property (STOP_REQ [*2] |-> FREQ_LIMIT == 8'h00)
      else $error("limit nonzero while stopped");
   a_raise_block: assert property (RAISE_BLOCK && $past(RAISE_BLOCK)
      |-> FREQ_LIMIT <= $past(FREQ_LIMIT))
      else $error("limit raised while blocked");
   a_step_size: assert property (FREQ_LIMIT < $past(FREQ_LIMIT) && FREQ_LIMIT != 8'h00
      |-> $past(FREQ_LIMIT) - FREQ_LIMIT == 8'h08 || $past(FREQ_LIMIT) - FREQ_LIMIT == 8'h1e
      || FREQ_LIMIT == FREQ_MIN_RST)
      else $error("odd reduction step");
endmodule // comp_protect_sva

bind comp_protect comp_protect_sva chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .FREQ_LIMIT(FREQ_LIMIT), .RAISE_BLOCK(RAISE_BLOCK), .STOP_REQ(STOP_REQ));

//--- tb/sense_model.sv
// Sensor readouts seen by the supervisor
`timescale 1ns/1ps
module sense_model
   import cps_pkg::*;
(
   input wire logic clk,
   input wire sense_s cmd,
   input wire logic [15:0] dc_cmd,
   output sense_s lvl,
   output logic [15:0] dc_lvl
);
   // Readings refresh once per clock like a sampled converter
   always @(posedge clk) begin
      lvl <= cmd;
      dc_lvl <= dc_cmd;
   end
endmodule // sense_model

//--- tb/tb_compressor_protection_supervisor.sv
// Self-checking bench for the compressor protection supervisor
`timescale 1ns/1ps
module tb_compressor_protection_supervisor
   import cps_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, key = 1'b0;
   logic [7:0] paddr = 8'h00, fq;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, rb, sr, irq, ev;
   sense_s cmd = '0, lv;
   logic [15:0] dcc = 16'hffff, dcl;
   int n_errors = 0, total_checks = 0, n;
   ////////////////////////////////////////////////////////////
   // Short timers keep the run small: tick 4, step 3, off 5, sag 8
   comp_protect #(.TICK_DIV(4), .STEP_T(16'h3), .OFF_T(16'h5), .SAG_T(16'h8)) dut_u (
      .SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .COIL_OUT_TEMP(lv.coil_out), .COIL_IN_TEMP(lv.coil_in), .DISCHARGE_TEMP(lv.disc),
      .AC_INPUT_CURRENT(lv.cur), .DC_LINK_VOLTAGE(dcl), .KEY_ONOFF(key), .FREQ_LIMIT(fq),
      .RAISE_BLOCK(rb), .STOP_REQ(sr), .IRQ(irq));
   sense_model sm_u (.clk(clk), .cmd(cmd), .dc_cmd(dcc), .lvl(lv), .dc_lvl(dcl));
   // Free-running 40 MHz clock
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; held until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(32'(pready), 32'h1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv & m, e);
   endtask
   task automatic ladder(input int p, input logic [15:0] l, input logic [15:0] h);
      apb(1'b1, A_TH_BASE + 8'(p * 16), 32'h64);
      apb(1'b1, A_TH_BASE + 8'(p * 16 + 4), 32'hc8);
      apb(1'b1, A_TH_BASE + 8'(p * 16 + 8), {16'h0, l});
      apb(1'b1, A_TH_BASE + 8'(p * 16 + 12), {16'h0, h});
   endtask
   // Waits (bounded) for the stop request to reach v; n holds the wait
   task automatic wstop(input logic v);
      n = 0;
      while (sr !== v && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(sr), 32'(v));
   endtask
   task automatic step(input logic [7:0] e);
      logic [7:0] f;
      f = fq;
      for (int i = 0; i < 200 && fq === f; i++) @(posedge clk);
      chk(32'(fq), 32'(e));
   endtask
   ////////////////////////////////////////////////////////////
   task automatic sc_regs();
      rd(A_FREQ, 32'hffff, {16'h0, FREQ_MAX_RST, FREQ_MIN_RST});
      rd(A_TH_BASE, 32'hffff, 32'hffff);
      rd(A_CLR_BASE, 32'hffff, {16'h0, CLR_TIME_RST});
      rd(8'h74, 32'hffffffff, 32'h0);
      chk(32'(ev), 32'h1);
   endtask
   task automatic sc_cool();
      ladder(P_COOL, 16'h12c, 16'h190);
      cmd.coil_out <= 16'h96;
      apb(1'b1, A_CTRL, 32'h3);
      repeat (60) @(posedge clk);
      chk(32'(sr), 32'h1);
      cmd.coil_out <= 16'h32;
      wstop(1'b0);
      chk(32'(fq), 32'(FREQ_MAX_RST));
      cmd.coil_out <= 16'h15e;
      step(8'h3c);
      chk(32'(rb), 32'h1);
      step(8'h1e);
      step(FREQ_MIN_RST);
      wstop(1'b1);
      cmd.coil_out <= 16'h32;
      wstop(1'b0);
      chk(32'(n >= 16), 32'h1);
   endtask
   task automatic sc_cur();
      apb(1'b1, A_IRQ_CLR, 32'hf);
      apb(1'b1, A_IRQ_EN, 32'h2);
      ladder(P_CUR, 16'h12c, 16'h190);
      cmd.cur <= 16'h1f4;
      wstop(1'b1);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h1);
      rd(A_IRQ_STAT, 32'h2, 32'h2);
      apb(1'b1, A_IRQ_EN, 32'h0);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, A_IRQ_EN, 32'h2);
      apb(1'b1, A_IRQ_CLR, 32'h2);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      cmd.cur <= 16'h32;
      wstop(1'b0);
   endtask
   task automatic sc_disc();
      ladder(P_DISC, 16'h12c, 16'h190);
      cmd.disc <= 16'hfa;
      step(8'h52);
      wstop(1'b1);
      rd(A_STATUS, 32'h700, 32'h100);
      cmd.disc <= 16'h32;
      apb(1'b1, A_CLR_BASE + 8'h08, 32'h2);
      wstop(1'b0);
      repeat (40) @(posedge clk);
      rd(A_STATUS, 32'h700, 32'h0);
      apb(1'b1, A_CLR_BASE + 8'h08, {16'h0, CLR_TIME_RST});
   endtask
   task automatic sc_lock();
      for (int i = 0; i < 6; i++) begin
         cmd.disc <= 16'h1f4;
         wstop(1'b1);
         cmd.disc <= 16'h32;
         if (i < 5) wstop(1'b0);
      end
      repeat (60) @(posedge clk);
      chk(32'(sr), 32'h1);
      rd(A_STATUS, 32'h4c, 32'h4c);
      apb(1'b1, A_CTRL, 32'h1);
      rd(A_STATUS, 32'h40, 32'h40);
      apb(1'b1, A_CTRL, 32'h3);
      key <= 1'b1;
      repeat (4) @(posedge clk);
      key <= 1'b0;
      repeat (4) @(posedge clk);
      rd(A_STATUS, 32'h40, 32'h0);
      wstop(1'b0);
   endtask
   task automatic sc_sag();
      apb(1'b1, A_SAG, 32'h200f0);
      dcc <= 16'h64;
      wstop(1'b1);
      rd(A_STATUS, 32'hc, 32'h8);
      dcc <= 16'hffff;
      wstop(1'b0);
   endtask
   // Heating watches the indoor coil; fan mode stops the compressor
   task automatic sc_heat();
      apb(1'b1, A_CTRL, 32'h1);
      wstop(1'b1);
      ladder(P_HEAT, 16'h12c, 16'h190);
      cmd.coil_in <= 16'h96;
      apb(1'b1, A_CTRL, 32'h2);
      repeat (60) @(posedge clk);
      chk(32'(sr), 32'h1);
      cmd.coil_in <= 16'h32;
      wstop(1'b0);
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence after a five-cycle reset
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      sc_regs();
      sc_cool();
      sc_cur();
      sc_disc();
      sc_lock();
      sc_sag();
      sc_heat();
      print_verdict();
   end
   // Watchdog far beyond the thousand or so cycles the run needs
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule // tb_compressor_protection_supervisor
